// *** shared/tcc_defs.svh ***
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define TCC_NUM_CH      7
`define TCC_IDX_W       8
`define TCC_WORD_W      16

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TCC_IDX_CTL     8'h00
`define TCC_IDX_CCTL0   8'h02
`define TCC_IDX_CNT     8'h10
`define TCC_IDX_CCR0    8'h12
`define TCC_IDX_IV      8'h2e
`define TCC_IDX_STEP    8'h02
`define TCC_IDX_SPAN    8'h0c

// ****************************************************************
// Channel control fields
// ****************************************************************
`define TCC_F_FLAG      0
`define TCC_F_OVR       1
`define TCC_F_OVD       2
`define TCC_F_LVL       3
`define TCC_F_IE        4
`define TCC_F_WS        5
`define TCC_F_CAP       8
`define TCC_F_LAT       10
`define TCC_F_SYNC      11
`define TCC_F_SS        12
`define TCC_F_ES        14

// ****************************************************************
// Common control fields, vector codes, reset values
// ****************************************************************
`define TCC_C_WRAP      0
`define TCC_C_WIE       1
`define TCC_C_GLOB_IE   15
`define TCC_IV_NONE     8'h00
`define TCC_IV_STEP     8'h02
`define TCC_IV_WRAP     8'h0e
`define TCC_RST_WORD    16'h0000

`endif

// *** shared/tcc_pkg.sv ***
package tcc_pkg;

   typedef logic [15:0] tcc_word_t;

   typedef enum logic [2:0]
   {
      TCC_WAVE_LEVEL     = 3'h0,
      TCC_WAVE_SET       = 3'h1,
      TCC_WAVE_TOG_RESET = 3'h2,
      TCC_WAVE_SET_RESET = 3'h3,
      TCC_WAVE_TOGGLE    = 3'h4,
      TCC_WAVE_RESET     = 3'h5,
      TCC_WAVE_TOG_SET   = 3'h6,
      TCC_WAVE_RESET_SET = 3'h7
   } tcc_wave_t;

endpackage

// *** shared/tcc_chan_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface tcc_chan_if;
   logic [1:0]        edge_sel;
   logic [1:0]        src_sel;
   logic              sync_en;
   logic              cap_en;
   tcc_pkg::tcc_wave_t wave_sel;
   logic              override;
   tcc_pkg::tcc_word_t ref_val;
   logic              level;
   logic              cap_ev;
   logic              match;
   logic              pin;

   modport core (output edge_sel, src_sel, sync_en, cap_en, wave_sel, override, ref_val,
                 input  level, cap_ev, match, pin);
   modport chan (input  edge_sel, src_sel, sync_en, cap_en, wave_sel, override, ref_val,
                 output level, cap_ev, match, pin);
endinterface

`default_nettype wire

// *** src/tcc_channel.sv ***
`timescale 1ns/1ps
`default_nettype none

module tcc_channel (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [15:0] counter_in,
   input  wire logic       step_in,
   input  wire logic       period_match_in,
   input  wire logic       timer_clr_in,
   input  wire logic       src_a_in,
   input  wire logic       src_b_in,
   tcc_chan_if.chan        ch
);

   logic sync_lvl_r;
   logic prev_r;
   logic pin_r;
   logic pin_nxt;

   // ****************************************************************
   // Capture edge detection
   // ****************************************************************
   wire sel_lvl = ch.src_sel[1] ? ch.src_sel[0] : (ch.src_sel[0] ? src_b_in : src_a_in); // R2 R8
   wire det_lvl = ch.sync_en ? sync_lvl_r : sel_lvl; // R5
   wire rise    = det_lvl & ~prev_r;
   wire fall    = ~det_lvl & prev_r;

   assign ch.level  = sel_lvl; // R4
   assign ch.cap_ev = ch.cap_en & ((ch.edge_sel[0] & rise) | (ch.edge_sel[1] & fall)); // R1 R2 R8
   assign ch.match  = ~ch.cap_en & step_in & (counter_in == ch.ref_val); // R1 R9 R16
   assign ch.pin    = pin_r;

   // ****************************************************************
   // Waveform output unit
   // ****************************************************************
   always_comb
   begin
      pin_nxt = pin_r;
      case (ch.wave_sel)
         tcc_pkg::TCC_WAVE_LEVEL:     pin_nxt = ch.override; // R11
         tcc_pkg::TCC_WAVE_SET:       pin_nxt = timer_clr_in ? 1'b0 : (ch.match | pin_r); // R12
         tcc_pkg::TCC_WAVE_TOG_RESET: pin_nxt = ch.match ? ~pin_r : (period_match_in ? 1'b0 : pin_r); // R14
         tcc_pkg::TCC_WAVE_SET_RESET: pin_nxt = ch.match ? 1'b1 : (period_match_in ? 1'b0 : pin_r); // R14
         tcc_pkg::TCC_WAVE_TOGGLE:    pin_nxt = ch.match ? ~pin_r : pin_r; // R13
         tcc_pkg::TCC_WAVE_RESET:     pin_nxt = ch.match ? 1'b0 : pin_r; // R12
         tcc_pkg::TCC_WAVE_TOG_SET:   pin_nxt = ch.match ? ~pin_r : (period_match_in ? 1'b1 : pin_r); // R14
         tcc_pkg::TCC_WAVE_RESET_SET: pin_nxt = ch.match ? 1'b0 : (period_match_in ? 1'b1 : pin_r); // R14
         default:                     pin_nxt = pin_r;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync_lvl_r <= 1'b0;
         prev_r     <= 1'b0;
         pin_r      <= 1'b0;
      end
      else
      begin
         sync_lvl_r <= sel_lvl;
         prev_r     <= det_lvl;
         pin_r      <= pin_nxt; // R10
      end
   end

endmodule

`default_nettype wire

// *** src/tcc_top.sv ***
// Behaviour
// R1: Snapshot_enable 1 selects capture, 0 selects compare, per channel.
// R2: Source_select picks source_a, source_b, ground or supply; edge_select picks edges.
// R3: A capture edge copies counter_value into channel_value and sets the flag.
// R4: Input_level always shows the selected capture input level.
// R5: Sync_snapshot delays the capture to the next timer clock edge.
// R6: A second capture before reading sets snapshot_overrun until software clears it.
// R7: Software changes input selection only while capture is disabled.
// R8: Toggling the low source bit with upper set gives one capture per toggle.
// R9: Compare match sets flag, pulses match, drives output, latches input level.
// R10: Every channel has an output unit updating on the clock edge.
// R11: Mode 000 output follows the level override bit.
// R12: Mode 001 sets on match until timer reset; mode 101 resets on match.
// R13: Mode 100 toggles on each match.
// R14: Dual modes act on channel match and period match as encoded.
// R15: Dual modes are not used on channel 0.
// R16: Matches count in both directions plus the period match.
// R17: Software passes through mode 7 when changing modes.
// R18: Channel 0 has its own interrupt; others share one with wrap.
// R19: Software sets or clears flags; requests need channel and global enables.
// R20: Channel 0 flag is top priority and clears when its request is serviced.
// R21: Vector_number shows highest enabled pending source; disabled ones are ignored.
// R22: Reading or writing vector_number clears the highest pending flag.
// R23: Codes 00h none, 02h..0Ch channels 1..6, 0Eh wrap.
// R24: Capture while the previous flag is still set counts as overrun.
`include "tcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tcc_top (
   input  wire logic        CLK_IN,
   input  wire logic        RESET_N_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic [15:0] COUNTER_IN,
   input  wire logic        COUNT_STEP_IN,
   input  wire logic        TIMER_CLR_IN,
   input  wire logic        WRAP_IN,
   input  wire logic [6:0]  SRC_A_IN,
   input  wire logic [6:0]  SRC_B_IN,
   input  wire logic        IRQ_CH0_ACK_IN,
   output logic [6:0]       CHAN_PIN_OUT,
   output logic             IRQ_CH0_OUT,
   output logic             IRQ_SHARED_OUT
);

   localparam int N = `TCC_NUM_CH;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [1:0]         es_r   [N];
   logic [1:0]         ss_r   [N];
   logic               sync_r [N];
   logic               cap_r  [N];
   tcc_pkg::tcc_wave_t ws_r   [N];
   logic               ie_r   [N];
   logic               ovd_r  [N];
   logic               lat_r  [N];
   logic               flag_r [N];
   logic               ovr_r  [N];
   tcc_pkg::tcc_word_t ccr_r  [N];
   logic               flag_nxt [N];
   logic               ovr_nxt  [N];
   logic               wrap_r;
   logic               wrap_nxt;
   logic               wie_r;
   logic               glob_ie_r;
   logic [7:0]         iv_code_r;
   logic [31:0]        prdata_r;
   logic               pready_r;
   logic               pslverr_r;
   logic               irq0_r;
   logic               irqs_r;
   logic [N-1:0]       level;
   logic [N-1:0]       cap_ev;
   logic [N-1:0]       match;
   logic [N-1:0]       pin;
   tcc_pkg::tcc_word_t rd_word;

   tcc_chan_if ch_if [N] ();

   // ****************************************************************
   // Address decode helpers
   // ****************************************************************
   function automatic logic in_bank(input logic [7:0] idx, input logic [7:0] base);
      in_bank = (idx >= base) && (idx <= base + `TCC_IDX_SPAN) && !idx[0];
   endfunction

   function automatic logic [2:0] chan_of(input logic [7:0] idx, input logic [7:0] base);
      logic [7:0] diff;
      diff    = idx - base;
      chan_of = diff[3:1];
   endfunction

   wire [7:0] idx       = PADDR_IN[9:2];
   wire       hi_zero   = (PADDR_IN[11:10] == 2'h0);
   wire       hit_ctl   = hi_zero && (idx == `TCC_IDX_CTL);
   wire       hit_cnt   = hi_zero && (idx == `TCC_IDX_CNT);
   wire       hit_iv    = hi_zero && (idx == `TCC_IDX_IV);
   wire       hit_cctl  = hi_zero && in_bank(idx, `TCC_IDX_CCTL0);
   wire       hit_ccr   = hi_zero && in_bank(idx, `TCC_IDX_CCR0);
   wire [2:0] sel_cctl  = chan_of(idx, `TCC_IDX_CCTL0);
   wire [2:0] sel_ccr   = chan_of(idx, `TCC_IDX_CCR0);
   wire       mapped    = hit_ctl | hit_cnt | hit_iv | hit_cctl | hit_ccr;
   wire       setup     = PSEL_IN & ~PENABLE_IN;
   wire       done      = PSEL_IN & PENABLE_IN & pready_r;
   wire       wr_done   = done & PWRITE_IN & mapped;
   wire       wr_ctl    = wr_done & hit_ctl;
   wire       iv_done   = done & hit_iv; // R22
   wire [15:0] wd       = PWDATA_IN[15:0];

   // ****************************************************************
   // Interrupt vector priority
   // ****************************************************************
   logic [N-1:0] pend;
   logic [7:0]   vec_code;

   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         pend[i] = flag_r[i] & ie_r[i]; // R21
      end
      vec_code = (wrap_r & wie_r) ? `TCC_IV_WRAP : `TCC_IV_NONE; // R23
      for (int i = N - 1; i >= 1; i--)
      begin
         if (pend[i])
         begin
            vec_code = 8'(i * `TCC_IV_STEP); // R21 R23
         end
      end
   end

   // ****************************************************************
   // Channels
   // ****************************************************************
   wire period_match = COUNT_STEP_IN & (COUNTER_IN == ccr_r[0]); // R14 R16

   for (genvar g = 0; g < N; g++)
   begin : g_ch
      assign ch_if[g].edge_sel = es_r[g];
      assign ch_if[g].src_sel  = ss_r[g];
      assign ch_if[g].sync_en  = sync_r[g];
      assign ch_if[g].cap_en   = cap_r[g];
      assign ch_if[g].wave_sel = ws_r[g];
      assign ch_if[g].override = ovd_r[g];
      assign ch_if[g].ref_val  = ccr_r[g];
      assign level[g]          = ch_if[g].level;
      assign cap_ev[g]         = ch_if[g].cap_ev;
      assign match[g]          = ch_if[g].match;
      assign pin[g]            = ch_if[g].pin;

      tcc_channel u_ch (
         .clk_in          (CLK_IN),
         .rst_n_in        (RESET_N_IN),
         .counter_in      (COUNTER_IN),
         .step_in         (COUNT_STEP_IN),
         .period_match_in (period_match),
         .timer_clr_in    (TIMER_CLR_IN),
         .src_a_in        (SRC_A_IN[g]),
         .src_b_in        (SRC_B_IN[g]),
         .ch              (ch_if[g])
      );

      wire wr_cctl = wr_done & hit_cctl & (sel_cctl == 3'(g));
      wire wr_ccr  = wr_done & hit_ccr & (sel_ccr == 3'(g));
      wire hw_set  = cap_ev[g] | match[g]; // R3 R9
      wire iv_clr  = iv_done & (iv_code_r == 8'(g * `TCC_IV_STEP)) & (g != 0); // R22
      wire ack_clr = (g == 0) & IRQ_CH0_ACK_IN; // R20
      wire sw_clr  = wr_cctl & ~wd[`TCC_F_FLAG]; // R19
      wire sw_set  = wr_cctl & wd[`TCC_F_FLAG]; // R19

      assign flag_nxt[g] = (hw_set | sw_set) ? 1'b1 : ((sw_clr | iv_clr | ack_clr) ? 1'b0 : flag_r[g]);
      assign ovr_nxt[g]  = (cap_ev[g] & flag_r[g]) ? 1'b1 :
                           (wr_cctl ? wd[`TCC_F_OVR] : ovr_r[g]); // R6 R24

      always_ff @(posedge CLK_IN or negedge RESET_N_IN)
      begin
         if (!RESET_N_IN)
         begin
            es_r[g]   <= 2'h0;
            ss_r[g]   <= 2'h0;
            sync_r[g] <= 1'b0;
            cap_r[g]  <= 1'b0;
            ws_r[g]   <= tcc_pkg::TCC_WAVE_LEVEL;
            ie_r[g]   <= 1'b0;
            ovd_r[g]  <= 1'b0;
            lat_r[g]  <= 1'b0;
            flag_r[g] <= 1'b0;
            ovr_r[g]  <= 1'b0;
            ccr_r[g]  <= `TCC_RST_WORD;
         end
         else
         begin
            if (wr_cctl)
            begin
               es_r[g]   <= wd[`TCC_F_ES +: 2];
               ss_r[g]   <= wd[`TCC_F_SS +: 2];
               sync_r[g] <= wd[`TCC_F_SYNC];
               cap_r[g]  <= wd[`TCC_F_CAP]; // R1
               ws_r[g]   <= tcc_pkg::tcc_wave_t'(wd[`TCC_F_WS +: 3]);
               ie_r[g]   <= wd[`TCC_F_IE];
               ovd_r[g]  <= wd[`TCC_F_OVD]; // R11
            end
            if (match[g])
            begin
               lat_r[g] <= level[g]; // R9
            end
            flag_r[g] <= flag_nxt[g];
            ovr_r[g]  <= ovr_nxt[g];
            if (cap_ev[g])
            begin
               ccr_r[g] <= COUNTER_IN; // R3
            end
            else if (wr_ccr)
            begin
               ccr_r[g] <= wd;
            end
         end
      end
   end

   // ****************************************************************
   // Read mux
   // ****************************************************************
   always_comb
   begin
      rd_word = `TCC_RST_WORD;
      if (hit_ctl)
      begin
         rd_word[`TCC_C_WRAP]    = wrap_r;
         rd_word[`TCC_C_WIE]     = wie_r;
         rd_word[`TCC_C_GLOB_IE] = glob_ie_r;
      end
      else if (hit_cnt)
      begin
         rd_word = COUNTER_IN;
      end
      else if (hit_iv)
      begin
         rd_word = {8'h00, vec_code}; // R21
      end
      else if (hit_ccr)
      begin
         rd_word = ccr_r[sel_ccr];
      end
      else if (hit_cctl)
      begin
         rd_word[`TCC_F_ES +: 2] = es_r[sel_cctl];
         rd_word[`TCC_F_SS +: 2] = ss_r[sel_cctl];
         rd_word[`TCC_F_SYNC]    = sync_r[sel_cctl];
         rd_word[`TCC_F_LAT]     = lat_r[sel_cctl];
         rd_word[`TCC_F_CAP]     = cap_r[sel_cctl];
         rd_word[`TCC_F_WS +: 3] = ws_r[sel_cctl];
         rd_word[`TCC_F_IE]      = ie_r[sel_cctl];
         rd_word[`TCC_F_LVL]     = level[sel_cctl]; // R4
         rd_word[`TCC_F_OVD]     = ovd_r[sel_cctl];
         rd_word[`TCC_F_OVR]     = ovr_r[sel_cctl];
         rd_word[`TCC_F_FLAG]    = flag_r[sel_cctl];
      end
   end

   // ****************************************************************
   // Bus answer, wrap flag, interrupt requests
   // ****************************************************************
   assign wrap_nxt = WRAP_IN | (wr_ctl & wd[`TCC_C_WRAP]) ? 1'b1 :
                     (((iv_done & (iv_code_r == `TCC_IV_WRAP)) | wr_ctl) ? 1'b0 : wrap_r); // R22

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         prdata_r  <= 32'h0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         iv_code_r <= `TCC_IV_NONE;
         wrap_r    <= 1'b0;
         wie_r     <= 1'b0;
         glob_ie_r <= 1'b0;
         irq0_r    <= 1'b0;
         irqs_r    <= 1'b0;
      end
      else
      begin
         pready_r  <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup)
         begin
            prdata_r  <= {16'h0, rd_word};
            iv_code_r <= vec_code;
         end
         wrap_r <= wrap_nxt;
         if (wr_ctl)
         begin
            wie_r     <= wd[`TCC_C_WIE];
            glob_ie_r <= wd[`TCC_C_GLOB_IE];
         end
         irq0_r <= glob_ie_r & pend[0] & ~IRQ_CH0_ACK_IN; // R18 R19 R20
         irqs_r <= glob_ie_r & ((|pend[N-1:1]) | (wrap_r & wie_r)) & ~iv_done; // R18 R22
      end
   end

   assign PRDATA_OUT     = prdata_r;
   assign PREADY_OUT     = pready_r;
   assign PSLVERR_OUT    = pslverr_r;
   assign CHAN_PIN_OUT   = pin;
   assign IRQ_CH0_OUT    = irq0_r;
   assign IRQ_SHARED_OUT = irqs_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   a_mode_gate_match: assert property (cap_r[1] && !cap_ev[1] && !done // R1
                                       |=> $stable(flag_r[1]))
      else $error("Flag moved in capture mode without capture");
   a_capture_copy: assert property (cap_ev[1] |=> (ccr_r[1] == $past(COUNTER_IN)) && flag_r[1]) // R3
      else $error("Capture did not copy counter");
   a_level_view: assert property (setup && hit_cctl && sel_cctl == 3'h1 && !match[1] // R4
                                  |=> PRDATA_OUT[`TCC_F_LVL] == $past(level[1]))
      else $error("Input level not shown");
   a_overrun_set: assert property (cap_ev[1] && flag_r[1] |=> ovr_r[1] [*2] // R6
                                   or (ovr_r[1] ##1 $past(wr_done)))
      else $error("Overrun not kept");
   a_match_latch: assert property (match[3] |=> flag_r[3] && lat_r[3] == $past(level[3])) // R9
      else $error("Match did not flag and latch");
   a_toggle_mode: assert property (match[3] && ws_r[3] == tcc_pkg::TCC_WAVE_TOGGLE // R13
                                   |=> CHAN_PIN_OUT[3] != $past(CHAN_PIN_OUT[3]))
      else $error("Toggle mode missed a match");
   a_ch0_request: assert property (glob_ie_r && pend[0] && !IRQ_CH0_ACK_IN |=> IRQ_CH0_OUT) // R18
      else $error("Channel 0 request missing");
   a_vector_top: assert property (pend[1] |-> vec_code == `TCC_IV_STEP) // R21
      else $error("Vector code wrong for channel 1");
   a_iv_clears: assert property (iv_done && iv_code_r == `TCC_IV_STEP && !match[1] // R22
                                 && !cap_ev[1] && !(wr_done && hit_cctl) |=> !flag_r[1])
      else $error("Vector access did not clear flag");

endmodule

`default_nettype wire

// *** sim/tcc_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module tcc_far_model (
   input  wire logic        clk_in,
   output logic      [15:0] cnt_out,
   output logic             step_out,
   output logic      [6:0]  sa_out,
   output logic      [6:0]  sb_out
);
   initial
   begin
      cnt_out = 16'h0000;
      step_out = 1'b0;
      sa_out = 7'h00;
      sb_out = 7'h00;
   end

   // Counter held at v while one source line moves
   task automatic set_src(input int ch, input logic b, input logic lv, input logic [15:0] v);
      cnt_out <= v;
      if (b)
         sb_out[ch] <= lv;
      else
         sa_out[ch] <= lv;
      repeat (2) @(posedge clk_in);
   endtask

   // One counting step onto v, then the counter moves away
   task automatic count_to(input logic [15:0] v);
      cnt_out <= v;
      step_out <= 1'b1;
      @(posedge clk_in);
      step_out <= 1'b0;
      cnt_out <= ~v;
   endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        pen;
   logic        pwr;
   logic [11:0] paddr;
   logic [31:0] pwd;
   logic [31:0] prd;
   logic        prdy;
   logic        perr;
   logic [15:0] cnt;
   logic        step;
   logic        clr;
   logic        wrap;
   logic        ack;
   logic [6:0]  sa;
   logic [6:0]  sb;
   logic [6:0]  pin;
   logic        irq0;
   logic        irqs;
   logic [31:0] rd;
   logic        err;
   logic [15:0] eccr;
   logic        ep;
   int          fails;
   int          compares;
   int          mflag [7];
   int          mie [7];
   int          mwrap;
   int          r;

   tcc_top u_tcc_top (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
      .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .COUNTER_IN(cnt), .COUNT_STEP_IN(step),
      .TIMER_CLR_IN(clr), .WRAP_IN(wrap), .SRC_A_IN(sa), .SRC_B_IN(sb),
      .IRQ_CH0_ACK_IN(ack), .CHAN_PIN_OUT(pin), .IRQ_CH0_OUT(irq0), .IRQ_SHARED_OUT(irqs));

   tcc_far_model u_tcc_far_model (.clk_in(clk), .cnt_out(cnt), .step_out(step),
      .sa_out(sa), .sb_out(sb));

   // ****************
   // Helpers
   // ****************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwd <= {16'h0000, d};
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (prdy !== 1'b1);
      chk("pready wait", 1, n);
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   function automatic logic [11:0] cc(input int n);
      return 12'(8 + 8 * n);
   endfunction

   task automatic wcc(input int n, input logic [15:0] v);
      mflag[n] = v[0];
      mie[n] = v[4];
      bus(1'b1, cc(n), v);
   endtask

   function automatic int vexp();
      for (int i = 1; i < 7; i++)
         if (mflag[i] != 0 && mie[i] != 0)
            return 2 * i;
      return (mwrap != 0) ? 14 : 0;
   endfunction

   function automatic logic wave(input int m, input logic p, input logic c, input logic z);
      case (m)
         1: return p | c;
         2: return z ? 1'b0 : p ^ c;
         3: return z ? 1'b0 : p | c;
         4: return p ^ c;
         5: return p & ~c;
         6: return z ? 1'b1 : p ^ c;
         7: return z ? 1'b1 : p & ~c;
         default: return p;
      endcase
   endfunction

   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      #100us;
      fails++;
      conclude();
   end

   // ****************
   // Scenarios
   // ****************
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h000;
      pwd = 32'h00000000;
      clr = 1'b0;
      wrap = 1'b0;
      ack = 1'b0;
      eccr = 16'h0000;
      r = $urandom(32'h2435);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 12'h000, 16'h0000);
      chk("ctl", 0, rd);
      bus(1'b0, 12'h0b8, 16'h0000);
      chk("vector", 0, rd);
      bus(1'b0, 12'h3fc, 16'h0000);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      for (int e = 1; e < 4; e++)
      begin
         wcc(1, {2'(e), 1'b0, e == 2, 12'h110});
         ep = 1'b0;
         for (int lv = 1; lv >= 0; lv--)
         begin
            r = $urandom;
            u_tcc_far_model.set_src(1, e == 2, lv[0], r[15:0]);
            if (e != 1 + lv)
            begin
               if (mflag[1] != 0)
                  ep = 1'b1;
               mflag[1] = 1;
               eccr = r[15:0];
            end
            bus(1'b0, cc(1), 16'h0000);
            chk("level", lv, rd[3]);
            chk("flag", mflag[1], rd[0]);
            chk("overrun", ep, rd[1]);
            bus(1'b0, cc(1) + 12'h040, 16'h0000);
            chk("snapshot", eccr, rd);
         end
      end
      wcc(2, 16'he900);
      for (int k = 0; k < 2; k++)
      begin
         r = $urandom;
         u_tcc_far_model.set_src(0, 1'b0, 1'b0, r[15:0]);
         bus(1'b1, cc(2), (k == 0) ? 16'hf900 : 16'he900);
         repeat (3) @(posedge clk);
         bus(1'b0, cc(2) + 12'h040, 16'h0000);
         chk("sw snapshot", r[15:0], rd);
      end
      bus(1'b1, cc(3) + 12'h040, 16'h0033);
      bus(1'b1, 12'h048, 16'h0077);
      ep = 1'b0;
      for (int m = 1; m < 8; m++)
      begin
         wcc(3, 16'h00e0);
         wcc(3, 16'(m << 5));
         for (int k = 0; k < 4; k++)
         begin
            u_tcc_far_model.count_to((k == 2) ? 16'h0077 : 16'h0033);
            ep = wave(m, ep, k != 2, k == 2);
            @(posedge clk);
            chk("pin", ep, pin[3]);
         end
         if (m == 1)
         begin
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            ep = 1'b0;
            @(posedge clk);
            chk("pin clear", ep, pin[3]);
         end
      end
      u_tcc_far_model.set_src(3, 1'b0, 1'b1, 16'h0000);
      u_tcc_far_model.count_to(16'h0033);
      @(posedge clk);
      bus(1'b0, cc(3), 16'h0000);
      chk("match flag", 1, rd[0]);
      chk("latched", 1, rd[10]);
      wcc(3, 16'h0004);
      repeat (2) @(posedge clk);
      chk("override", 1, pin[3]);
      bus(1'b1, 12'h000, 16'h8002);
      wcc(0, 16'h0011);
      repeat (2) @(posedge clk);
      chk("irq ch0", 1, irq0);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq ch0 done", 0, irq0);
      wcc(1, 16'h0011);
      wcc(2, 16'h0000);
      wcc(4, 16'h0001);
      wcc(5, 16'h0011);
      wcc(6, 16'h0011);
      wrap <= 1'b1;
      @(posedge clk);
      wrap <= 1'b0;
      mwrap = 1;
      bus(1'b1, 12'h000, 16'h0003);
      repeat (2) @(posedge clk);
      chk("irq gated", 0, irqs);
      bus(1'b1, 12'h000, 16'h8003);
      do
      begin
         r = vexp();
         repeat (2) @(posedge clk);
         chk("irq shared", r != 0, irqs);
         bus(1'b0, 12'h0b8, 16'h0000);
         chk("vector", r, rd);
         if (r == 14)
            mwrap = 0;
         else if (r != 0)
            mflag[r / 2] = 0;
      end
      while (r != 0);
      wcc(1, 16'h0011);
      bus(1'b1, 12'h0b8, 16'h0000);
      bus(1'b0, cc(1), 16'h0000);
      chk("iv write clear", 0, rd[0]);
      conclude();
   end
endmodule

`default_nettype wire
